// [rtl/sfcad_pkg.sv]
// constants, types and opcode decode for the serial flash command front end
// Function
// (RQ1) address: 3 spare, 12 page, 9 offset bits
// (RQ2) reads 03h/0Bh/D2h/E8h take 0/1/4/4 dummies
// (RQ3) buffer opcodes decode offset only, some dummies
// (RQ4) page opcodes decode page; 82h/85h both
// (RQ5) 50h keeps upper 9, 7Ch upper 3 page bits
// (RQ6) after reset: mode 3, output undriven
// (RQ7) fresh select fall needed after reset
// (RQ8) select fall samples clock idle level
// (RQ9) held in reset, all commands ignored
// (RQ10) host waits 70 us before first select
// (RQ11) host waits 20 ms before program/erase
// (RQ12) device rests in standby until selected
// (RQ13) bits msb first, select low throughout
package sfcad_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ                   = 100;
  localparam int unsigned SUPPLY_TO_SELECT_DELAY_US = 70;
  localparam int unsigned POWERUP_WRITE_DELAY_MS    = 20;
  localparam int unsigned US_PER_MS                 = 1000;
  localparam int unsigned SUPPLY_TO_SELECT_CYCLES   = SUPPLY_TO_SELECT_DELAY_US * CLK_MHZ;
  localparam int unsigned POWERUP_WRITE_CYCLES      =
    POWERUP_WRITE_DELAY_MS * US_PER_MS * CLK_MHZ;
  localparam int unsigned TIMER_W                   = 22;
  localparam logic [7:0]  SCK_HALF_LAST             = 8'h01; // half period = 2 cycles
  localparam logic [7:0]  FRAME_GAP_LAST            = 8'h03; // 4 cycles deselected

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int unsigned OPCODE_W   = 8;
  localparam int unsigned PAGE_W     = 12;
  localparam int unsigned OFFSET_W   = 9;
  localparam int unsigned ADDR_W     = 24;
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned FRAME_W    = 64;
  localparam int unsigned BITS_W     = 7;
  localparam int unsigned PAGE_LSB   = 9;
  localparam int unsigned PAGE_MSB   = 20;
  localparam logic [6:0]  OPCODE_BITS = 7'h08;
  localparam logic [6:0]  ADDR_BITS   = 7'h18;
  localparam logic [6:0]  WORD_BITS   = 7'h20;
  localparam logic [2:0]  SPARE_BITS  = 3'h0;

  // field masks
  localparam logic [11:0] PAGE_ALL    = 12'hfff;
  localparam logic [11:0] PAGE_BLOCK  = 12'hff8;
  localparam logic [11:0] PAGE_SECTOR = 12'he00;
  localparam logic [11:0] PAGE_NONE   = 12'h000;
  localparam logic [8:0]  OFFSET_ALL  = 9'h1ff;
  localparam logic [8:0]  OFFSET_NONE = 9'h000;
  localparam logic [2:0]  DUMMY_NONE  = 3'h0;
  localparam logic [2:0]  DUMMY_ONE   = 3'h1;
  localparam logic [2:0]  DUMMY_FOUR  = 3'h4;

  typedef struct packed {
    logic        known;
    logic        has_addr;
    logic        write;
    logic [2:0]  dummy;
    logic [11:0] page_mask;
    logic [8:0]  offset_mask;
  } sfcad_decode_type;

  // ----------------------------------------------------------------
  // opcode table
  // ----------------------------------------------------------------
  function automatic sfcad_decode_type sfcad_decode(input logic [7:0] op);
    sfcad_decode_type d;
    d = '{known: 1'b1, has_addr: 1'b1, write: 1'b0, dummy: DUMMY_NONE,
          page_mask: PAGE_ALL, offset_mask: OFFSET_ALL};
    unique case (op)
      8'h03: ;
      8'h0b: d.dummy = DUMMY_ONE; // RQ2
      8'hd2, 8'he8: d.dummy = DUMMY_FOUR; // RQ2
      8'h82, 8'h85: d.write = 1'b1; // RQ4
      8'h53, 8'h55, 8'h60, 8'h61: d.offset_mask = OFFSET_NONE; // RQ4
      8'h58, 8'h59, 8'h81, 8'h83, 8'h86, 8'h88, 8'h89: begin // RQ4
        d.offset_mask = OFFSET_NONE;
        d.write       = 1'b1;
      end
      8'h50, 8'h7c: begin // RQ5
        d.page_mask   = (op == 8'h50) ? PAGE_BLOCK : PAGE_SECTOR;
        d.offset_mask = OFFSET_NONE;
        d.write       = 1'b1;
      end
      8'h77: begin
        d.page_mask   = PAGE_NONE;
        d.offset_mask = OFFSET_NONE;
        d.write       = 1'b1;
      end
      8'h84, 8'h87, 8'hd1, 8'hd3, 8'hd4, 8'hd6: begin // RQ3
        d.page_mask = PAGE_NONE;
        d.dummy     = (op == 8'hd4 || op == 8'hd6) ? DUMMY_ONE : DUMMY_NONE;
      end
      8'h9f, 8'hb9, 8'hab, 8'hd7: d.has_addr = 1'b0;
      default: begin
        d.known    = 1'b0;
        d.has_addr = 1'b0;
      end
    endcase
    return d;
  endfunction

  // total serial bits of a command, dummies included
  function automatic logic [6:0] sfcad_frame_bits(input sfcad_decode_type d);
    return OPCODE_BITS + (d.has_addr ? ADDR_BITS : 7'h00) + {1'b0, d.dummy, 3'h0};
  endfunction

endpackage

// [rtl/sfcad_link_if.sv]
// serial link between host controller and flash command front end
interface sfcad_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;

  modport dev (
    input  cs_n,
    input  sck,
    input  si,
    output so,
    output so_oe
  );

  modport host (
    output cs_n,
    output sck,
    output si,
    input  so,
    input  so_oe
  );
endinterface

// [rtl/sfcad_device.sv]
// device end: serial command and address capture, mode select, reset state
module sfcad_device
  import sfcad_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  sfcad_link_if.dev        link,
  output logic             cmd_valid,
  output logic             cmd_known,
  output logic [7:0]       cmd_opcode,
  output logic [11:0]      cmd_page,
  output logic [8:0]       cmd_offset,
  output logic [2:0]       cmd_dummy,
  output logic             clock_mode3,
  output logic             standby
);

  // ----------------------------------------------------------------
  // link side state (clocked by the host's serial clock)
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [6:0] bits;
    logic [7:0] op;
    logic [31:0] shift;
    logic       done;
  } sfcad_frame_type;

  typedef struct packed {
    logic [31:0] word;
    logic        flag;
  } sfcad_hand_type;

  sfcad_frame_type  frame;
  sfcad_frame_type  next_frame;
  sfcad_hand_type   hand;
  sfcad_hand_type   next_hand;
  logic             link_rst;
  sfcad_decode_type link_dec;
  logic [6:0]       link_nbits;
  logic [31:0]      link_nshift;
  logic [7:0]       link_op;

  // select high ends the frame: the serial clock may stop right after
  // the last bit, so the frame state cannot wait for another edge
  assign link_rst = rst | link.cs_n; // RQ13

  // bit accumulation, msb first, one bit per rising edge
  always_comb begin
    next_frame  = frame;
    next_hand   = hand;
    link_nbits  = frame.bits + 7'h01;
    link_nshift = {frame.shift[30:0], link.si}; // RQ13
    link_op     = (link_nbits == OPCODE_BITS) ? link_nshift[7:0] : frame.op;
    link_dec    = sfcad_decode(link_op);
    if (!frame.done) begin
      next_frame.bits  = link_nbits;
      next_frame.shift = link_nshift;
      next_frame.op    = link_op;
      // opcode plus 24 address bits complete: park the word
      if (link_dec.has_addr && link_nbits == WORD_BITS) begin // RQ1
        next_hand.word = link_nshift;
      end else if (!link_dec.has_addr && link_nbits == OPCODE_BITS) begin
        next_hand.word = {link_nshift[7:0], 24'h000000};
      end
      // dummy bytes are counted but never stored
      if (link_nbits == sfcad_frame_bits(link_dec)) begin // RQ2 RQ3
        next_frame.done = 1'b1;
        next_hand.flag  = ~hand.flag;
      end
    end
  end

  // per-frame state, cleared whenever the device is deselected
  always_ff @(posedge link.sck or posedge link_rst) begin
    if (link_rst) begin
      frame <= '0;
    end else begin
      frame <= next_frame;
    end
  end

  // handover word and event toggle survive deselect until picked up
  always_ff @(posedge link.sck or posedge rst) begin
    if (rst) begin
      hand <= '0;
    end else begin
      hand <= next_hand;
    end
  end

  // ----------------------------------------------------------------
  // system side state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  cs_sync;
    logic [2:0]  sck_sync;
    logic [2:0]  tog_sync;
    logic        cs_filt;
    logic        sck_filt;
    logic        frame_ok;
    logic        mode3;
    logic        valid;
    logic        known;
    logic [7:0]  opcode;
    logic [11:0] page;
    logic [8:0]  offset;
    logic [2:0]  dummy;
    logic        idle;
    logic        so;
    logic        so_oe;
  } sfcad_dev_type;

  sfcad_dev_type    st;
  sfcad_dev_type    next_st;
  sfcad_decode_type sys_dec;
  logic             cs_fall;
  logic             cs_rise;
  logic             word_event;

  // synchronisers, filters, mode pick and command capture
  always_comb begin
    next_st          = st;
    next_st.cs_sync  = {st.cs_sync[1:0], link.cs_n};
    next_st.sck_sync = {st.sck_sync[1:0], link.sck};
    next_st.tog_sync = {st.tog_sync[1:0], hand.flag};
    // a pin change only counts once two late stages agree
    if (st.cs_sync[1] == st.cs_sync[2]) begin
      next_st.cs_filt = st.cs_sync[2];
    end
    if (st.sck_sync[1] == st.sck_sync[2]) begin
      next_st.sck_filt = st.sck_sync[2];
    end
    cs_fall    = st.cs_filt & ~next_st.cs_filt;
    cs_rise    = ~st.cs_filt & next_st.cs_filt;
    word_event = st.tog_sync[1] ^ st.tog_sync[2];
    sys_dec    = sfcad_decode(hand.word[31:24]);
    // filter resets low, so a select held low through reset never
    // looks like a fall: only a fresh one opens a frame
    if (cs_fall) begin
      next_st.frame_ok = 1'b1; // RQ7
      next_st.mode3    = st.sck_filt; // RQ8
    end else if (cs_rise) begin
      next_st.frame_ok = 1'b0;
    end
    next_st.valid = 1'b0;
    if (word_event && st.frame_ok) begin // RQ7
      next_st.valid  = 1'b1;
      next_st.known  = sys_dec.known;
      next_st.opcode = hand.word[31:24];
      next_st.page   = hand.word[PAGE_MSB:PAGE_LSB] & sys_dec.page_mask; // RQ4 RQ5
      next_st.offset = hand.word[OFFSET_W-1:0] & sys_dec.offset_mask; // RQ3 RQ4
      next_st.dummy  = sys_dec.dummy; // RQ2
    end
    next_st.idle  = ~next_st.frame_ok; // RQ12
    // no data phase here: the output stays released
    next_st.so    = 1'b0;
    next_st.so_oe = 1'b0; // RQ6
  end

  // reset holds everything quiet; mode 3 and standby are the defaults
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin // RQ9
      st       <= '0;
      st.mode3 <= 1'b1; // RQ6
      st.idle  <= 1'b1; // RQ12
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cmd_valid   = st.valid;
  assign cmd_known   = st.known;
  assign cmd_opcode  = st.opcode;
  assign cmd_page    = st.page;
  assign cmd_offset  = st.offset;
  assign cmd_dummy   = st.dummy;
  assign clock_mode3 = st.mode3;
  assign standby     = st.idle;
  assign link.so     = st.so;
  assign link.so_oe  = st.so_oe;

endmodule

// [rtl/sfcad_host.sv]
// host end: power-up gating, serial clock divider and command shifter
module sfcad_host
  import sfcad_pkg::*;
#(
  parameter int unsigned SELECT_CYCLES = SUPPLY_TO_SELECT_CYCLES,
  parameter int unsigned WRITE_CYCLES  = POWERUP_WRITE_CYCLES
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  sfcad_link_if.host       link,
  input  wire logic        cmd_start,
  input  wire logic [7:0]  cmd_opcode,
  input  wire logic [11:0] cmd_page,
  input  wire logic [8:0]  cmd_offset,
  input  wire logic        cmd_mode3,
  output logic             busy,
  output logic             done,
  output logic             refused,
  output logic             read_ok,
  output logic             write_ok
);

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_LEAD  = 4'b0010,
    S_SHIFT = 4'b0100,
    S_TAIL  = 4'b1000
  } sfcad_state_type;

  typedef struct packed {
    sfcad_state_type state;
    logic [21:0]     timer;
    logic [7:0]      half;
    logic [6:0]      bits;
    logic [6:0]      total;
    logic [63:0]     shift;
    logic            mode3;
    logic            sck;
    logic            cs_n;
    logic            si;
    logic            busy;
    logic            done;
    logic            refused;
    logic            read_ok;
    logic            write_ok;
  } sfcad_host_state_type;

  localparam logic [21:0] SELECT_LAST = SELECT_CYCLES[21:0];
  localparam logic [21:0] WRITE_LAST  = WRITE_CYCLES[21:0];

  sfcad_host_state_type st;
  sfcad_host_state_type next_st;
  sfcad_decode_type     dec;
  logic                 half_end;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_st         = st;
    next_st.done    = 1'b0;
    next_st.refused = 1'b0;
    dec             = sfcad_decode(cmd_opcode);
    half_end        = (st.half == SCK_HALF_LAST);
    // power-up timer saturates at the longer wait
    if (st.timer != WRITE_LAST) begin
      next_st.timer = st.timer + 22'h000001;
    end
    next_st.read_ok  = (st.timer >= SELECT_LAST); // RQ10
    next_st.write_ok = (st.timer >= WRITE_LAST); // RQ11
    next_st.half     = st.half + 8'h01;
    unique case (st.state)
      S_IDLE: begin
        next_st.half = 8'h00;
        if (cmd_start) begin
          // too early: refuse rather than queue, the caller retries
          if (!st.read_ok || (dec.write && !st.write_ok)) begin // RQ10 RQ11
            next_st.refused = 1'b1;
          end else begin
            next_st.state = S_LEAD;
            next_st.busy  = 1'b1;
            next_st.mode3 = cmd_mode3;
            next_st.sck   = cmd_mode3;
            next_st.total = sfcad_frame_bits(dec);
            next_st.shift = {cmd_opcode, SPARE_BITS, cmd_page, cmd_offset, 32'h0}; // RQ1
            next_st.bits  = 7'h00;
          end
        end
      end
      // clock settles at its idle level before select falls
      S_LEAD: begin
        if (st.half == FRAME_GAP_LAST) begin
          next_st.state = S_SHIFT;
          next_st.half  = 8'h00;
          next_st.cs_n  = 1'b0; // RQ7 RQ13
          next_st.si    = st.shift[FRAME_W-1];
          next_st.shift = {st.shift[62:0], 1'b0};
        end
      end
      S_SHIFT: begin
        if (half_end) begin
          next_st.half = 8'h00;
          next_st.sck  = ~st.sck;
          if (!st.sck) begin
            next_st.bits = st.bits + 7'h01;
            if (st.bits + 7'h01 == st.total) begin
              next_st.state = S_TAIL;
            end
          end else if (st.bits != 7'h00) begin
            // data changes on the falling edge, msb first
            next_st.si    = st.shift[FRAME_W-1]; // RQ13
            next_st.shift = {st.shift[62:0], 1'b0};
          end
        end
      end
      S_TAIL: begin
        if (half_end) begin
          next_st.sck = st.mode3;
        end
        if (st.half == FRAME_GAP_LAST) begin
          next_st.state = S_IDLE;
          next_st.cs_n  = 1'b1;
          next_st.si    = 1'b0;
          next_st.busy  = 1'b0;
          next_st.done  = 1'b1;
        end
      end
      default: next_st.state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st       <= '0;
      st.state <= S_IDLE;
      st.cs_n  <= 1'b1;
      st.sck   <= 1'b1;
      st.mode3 <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.cs_n = st.cs_n;
  assign link.sck  = st.sck;
  assign link.si   = st.si;
  assign busy      = st.busy;
  assign done      = st.done;
  assign refused   = st.refused;
  assign read_ok   = st.read_ok;
  assign write_ok  = st.write_ok;

endmodule

// [verification/sfcad_asserts.sv]
// checker: link framing and timing between the host and device ends
module sfcad_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [6:0] rise_cnt;
  logic       sck_q;

  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  // rising sck edges of the open frame; select high clears the count
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rise_cnt <= 7'h00;
      sck_q    <= 1'b1;
    end else begin
      sck_q <= sck;
      if (cs_n)
        rise_cnt <= 7'h00;
      else if (sck && !sck_q)
        rise_cnt <= rise_cnt + 7'h01;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // link rules
  // ------------------------------------------------------------
  chk_so_released: assert property (!so_oe && !so)
    else $error("serial output driven");
  chk_reset_idle: assert property ($fell(rst) |-> cs_n && sck)
    else $error("link not idle in mode 3 after reset");
  chk_select_gap: assert property ($rose(cs_n) |-> cs_n [*3])
    else $error("select reasserted too soon");
  chk_si_stable: assert property (!cs_n && $rose(sck) |-> $stable(si))
    else $error("serial input moved at sampling edge");
  chk_sck_half: assert property (!cs_n && $changed(sck) |=> $stable(sck))
    else $error("serial clock half period too short");
  // idle level must still stand when the device samples it
  chk_mode_hold: assert property ($fell(cs_n) |=> $stable(sck) ##1 $changed(sck))
    else $error("serial clock moved early after select");
  chk_frame_len: assert property ($rose(cs_n)
    |-> rise_cnt inside {7'h08, 7'h20, 7'h28, 7'h40})
    else $error("frame length not a legal command size");
  // bits 8 to 10 of a frame are the spare address bits
  chk_spare_zero: assert property (!cs_n && $rose(sck)
    && rise_cnt >= 7'h08 && rise_cnt <= 7'h0a |-> !si)
    else $error("spare address bit not zero");
  chk_dummy_zero: assert property (!cs_n && $rose(sck) && rise_cnt >= 7'h20 |-> !si)
    else $error("dummy bit not zero");
endmodule

// [verification/serial_flash_cmd_addr_decode_bench.sv]
// bench: host and device ends joined by the link, driven from a command table
module serial_flash_cmd_addr_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [7:0]  op;
    logic [11:0] pg;
    logic [8:0]  of;
    logic        m3;
    logic [11:0] ep;
    logic [8:0]  eo;
    logic [2:0]  ed;
  } sfcad_row_type;

  logic          clk_sys = 1'b0;
  logic          rst = 1'b1;
  logic          cmd_start = 1'b0;
  logic [7:0]    op = 8'h00;
  logic [11:0]   pg = 12'h000;
  logic [8:0]    of = 9'h000;
  logic          m3 = 1'b1;
  logic          busy, done, refused, read_ok, write_ok;
  logic          cmd_valid, cmd_known, clock_mode3, standby;
  logic [7:0]    d_op;
  logic [11:0]   d_pg;
  logic [8:0]    d_of;
  logic [2:0]    d_dum;
  bit            seen;
  int            n_mismatch = 0;
  int            checks_done = 0;
  sfcad_row_type tbl [18];

  always #5 clk_sys = ~clk_sys;

  // ------------------------------------------------------------
  // the two ends and the checker
  // ------------------------------------------------------------
  sfcad_link_if link ();
  // short power-up counts keep the run brief
  sfcad_host #(.SELECT_CYCLES(20), .WRITE_CYCLES(60)) sfcad_host_inst (
    .clk_sys(clk_sys), .rst(rst), .link(link), .cmd_start(cmd_start), .cmd_opcode(op),
    .cmd_page(pg), .cmd_offset(of), .cmd_mode3(m3), .busy(busy), .done(done),
    .refused(refused), .read_ok(read_ok), .write_ok(write_ok));
  sfcad_device sfcad_device_inst (
    .clk_sys(clk_sys), .rst(rst), .link(link), .cmd_valid(cmd_valid), .cmd_known(cmd_known),
    .cmd_opcode(d_op), .cmd_page(d_pg), .cmd_offset(d_of), .cmd_dummy(d_dum),
    .clock_mode3(clock_mode3), .standby(standby));
  sfcad_asserts sfcad_asserts_inst (
    .clk_sys(clk_sys), .rst(rst), .cs_n(link.cs_n), .sck(link.sck), .si(link.si),
    .so(link.so), .so_oe(link.so_oe));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // a spent wait bound counts as a mismatch and closes the run
  task automatic give_up;
    chk(40'h0, 40'h1);
    end_sim();
  endtask

  task automatic start(input logic [7:0] o, input logic [11:0] p, input logic [8:0] f,
                       input logic m);
    @(negedge clk_sys);
    cmd_start = 1'b1;
    op = o;
    pg = p;
    of = f;
    m3 = m;
    @(negedge clk_sys);
    cmd_start = 1'b0;
  endtask

  task automatic wait_flag(input bit w);
    for (int n = 0; n < 300; n++) begin
      @(negedge clk_sys);
      if ((w ? write_ok : read_ok) === 1'b1)
        return;
    end
    give_up();
  endtask

  task automatic expect_refused;
    seen = 0;
    repeat (3) begin
      if (refused === 1'b1)
        seen = 1;
      @(negedge clk_sys);
    end
    chk(seen, 1'b1);
    chk(busy, 1'b0);
  endtask

  // fields are looked at in the one cycle that cmd_valid stands
  task automatic run_row(input sfcad_row_type r);
    bit got_v;
    bit got_d;
    got_v = 0;
    got_d = 0;
    start(r.op, r.pg, r.of, r.m3);
    // an accepted request shows busy from the cycle after it is taken
    chk(busy, 1'b1);
    for (int n = 0; n < 600 && !(got_v && got_d); n++) begin
      @(negedge clk_sys);
      got_d |= (done === 1'b1);
      if (cmd_valid === 1'b1) begin
        got_v = 1;
        if (r.op == 8'h00)
          chk({cmd_known, d_op}, {1'b0, r.op});
        else
          chk({cmd_known, d_op, d_pg, d_of, d_dum},
              {1'b1, r.op, r.ep, r.eo, r.ed});
        chk({clock_mode3, standby}, {r.m3, 1'b0});
      end
    end
    if (!(got_v && got_d))
      give_up();
    repeat (12) @(negedge clk_sys);
    chk(standby, 1'b1);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    tbl = '{
      '{8'h03, 12'habc, 9'h1a5, 1'b1, 12'habc, 9'h1a5, 3'h0},
      '{8'h0b, 12'h123, 9'h0ff, 1'b0, 12'h123, 9'h0ff, 3'h1},
      '{8'hd2, 12'hfff, 9'h1ff, 1'b1, 12'hfff, 9'h1ff, 3'h4},
      '{8'he8, 12'h800, 9'h001, 1'b0, 12'h800, 9'h001, 3'h4},
      '{8'h84, 12'habc, 9'h155, 1'b1, 12'h000, 9'h155, 3'h0},
      '{8'h87, 12'hfff, 9'h0aa, 1'b0, 12'h000, 9'h0aa, 3'h0},
      '{8'hd1, 12'h321, 9'h100, 1'b1, 12'h000, 9'h100, 3'h0},
      '{8'hd3, 12'h7a5, 9'h1ff, 1'b0, 12'h000, 9'h1ff, 3'h0},
      '{8'hd4, 12'hfff, 9'h1ff, 1'b1, 12'h000, 9'h1ff, 3'h1},
      '{8'hd6, 12'h555, 9'h0aa, 1'b0, 12'h000, 9'h0aa, 3'h1},
      '{8'h53, 12'ha5a, 9'h1ff, 1'b1, 12'ha5a, 9'h000, 3'h0},
      '{8'h82, 12'h456, 9'h0ab, 1'b0, 12'h456, 9'h0ab, 3'h0},
      '{8'h85, 12'hfff, 9'h1ff, 1'b1, 12'hfff, 9'h1ff, 3'h0},
      '{8'h50, 12'hfff, 9'h1ff, 1'b0, 12'hff8, 9'h000, 3'h0},
      '{8'h7c, 12'hfff, 9'h1ff, 1'b1, 12'he00, 9'h000, 3'h0},
      '{8'h77, 12'h5a5, 9'h15a, 1'b0, 12'h000, 9'h000, 3'h0},
      '{8'h9f, 12'hfff, 9'h1ff, 1'b1, 12'h000, 9'h000, 3'h0},
      '{8'h00, 12'hfff, 9'h1ff, 1'b0, 12'h000, 9'h000, 3'h0}};
    repeat (8) @(negedge clk_sys);
    chk({clock_mode3, standby, cmd_valid, link.so_oe, link.cs_n}, 5'h19);
    rst = 1'b0;
    start(8'h03, 12'h001, 9'h001, 1'b1);
    expect_refused();
    wait_flag(1'b0);
    start(8'h82, 12'h001, 9'h001, 1'b1);
    expect_refused();
    // a read is already allowed while program and erase are still held off
    chk(write_ok, 1'b0);
    run_row(tbl[0]);
    wait_flag(1'b1);
    foreach (tbl[i])
      run_row(tbl[i]);
    // reset in mid-frame: the open frame must never complete
    start(8'h0b, 12'h123, 9'h045, 1'b0);
    repeat (40) @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk({clock_mode3, standby, cmd_valid, link.so_oe, link.cs_n}, 5'h19);
    rst = 1'b0;
    seen = 0;
    repeat (300) begin
      @(negedge clk_sys);
      if (cmd_valid === 1'b1)
        seen = 1;
    end
    chk(seen, 1'b0);
    wait_flag(1'b1);
    run_row(tbl[0]);
    end_sim();
  end
endmodule
